// [hdl/pfs_port.v]
// Behaviour
// - Mode pin high or open selects printer
// - Pulse low strobe to latch byte
// - Bytes move over eight-line data bus
// - Drive auto line feed low when requested
// - Drive printer reset low to initialise
// - Drive select low to select printer
// - Density output picks low or high rate
// - Drive select and motor outputs low-active
// - Head output low head0, high head1
// - Direction low inwards, high outwards
// - One step pulse per track moved
// - Serial write data on open-drain output
// - Write gate low only while writing
`timescale 1ns/1ps
`default_nettype none
`include "pfs_consts.vh"
module pfs_port #(
	parameter FIFO_DEPTH = `PFS_FIFO_D,
	parameter SETUP_CYC  = `PFS_SETUP_CYC,
	parameter STROBE_CYC = `PFS_STROBE_CYC,
	parameter HOLD_CYC   = `PFS_HOLD_CYC,
	parameter STEP_CYC   = `PFS_STEP_PULSE_CYC,
	parameter GAP_CYC    = `PFS_STEP_GAP_CYC
) (
	// Clock and reset
	input  wire       mclk,
	input  wire       rst_n,
	// Mode pin
	input  wire       port_mode_select,
	// Host byte stream to printer
	input  wire       tx_valid,
	output wire       tx_ready,
	input  wire [7:0] tx_byte,
	// Host printer controls
	input  wire       want_auto_feed,
	input  wire       want_init,
	input  wire       want_select,
	input  wire       want_read,
	// Host received byte (reverse direction)
	output reg        rx_valid_q,
	output reg  [7:0] rx_byte_q,
	// Printer status to host
	output reg        stat_fault_q,
	output reg        stat_paper_out_q,
	output reg        stat_online_q,
	output reg        stat_busy_q,
	output reg        stat_ack_q,
	// Printer pins
	output reg        printer_latch_pulse_n_oe_q,
	output reg        auto_line_feed_n_oe_q,
	output reg        printer_init_n_oe_q,
	output reg        printer_select_out_n_oe_q,
	input  wire [7:0] printer_byte_bus_i,
	output reg  [7:0] printer_byte_bus_o_q,
	output reg        printer_byte_bus_oe_q,
	input  wire       printer_fault_n,
	input  wire       printer_ack_n,
	input  wire       printer_busy,
	input  wire       paper_out_in,
	input  wire       printer_online_in,
	// Host floppy controls
	input  wire       want_high_density,
	input  wire       want_drive,
	input  wire       want_motor,
	input  wire       want_head1,
	input  wire       seek_start,
	input  wire       seek_outward,
	input  wire [7:0] seek_tracks,
	output reg        seek_busy_q,
	input  wire       wr_active,
	input  wire       wr_bit,
	// Floppy status to host
	output reg        fd_index_q,
	output reg        fd_track0_q,
	output reg        fd_protected_q,
	output reg        fd_read_bit_q,
	output reg        fd_changed_q,
	// Floppy pins (open drain: oe high pulls low)
	output reg        density_choice_oe_q,
	input  wire       index_hole_n,
	input  wire       outermost_track_in,
	input  wire       write_protect_n,
	input  wire       read_stream_n,
	input  wire       disk_changed_in,
	output reg        drive_activate_n_oe_q,
	output reg        spindle_on_n_oe_q,
	output reg        head_choice_oe_q,
	output reg        head_dir_oe_q,
	output reg        head_step_n_oe_q,
	output reg        write_stream_n_oe_q,
	output reg        write_gate_out_n_oe_q
);
	localparam ST_IDLE  = 4'b0001;
	localparam ST_SETUP = 4'b0010;
	localparam ST_PULSE = 4'b0100;
	localparam ST_HOLD  = 4'b1000;
	localparam SK_IDLE  = 3'b001;
	localparam SK_PULSE = 3'b010;
	localparam SK_GAP   = 3'b100;

	reg  [3:0]                st_q;
	reg  [`PFS_CNT_W-1:0]     cnt_q;
	reg  [7:0]                byte_q;
	reg  [2:0]                sk_q;
	reg  [`PFS_CNT_W-1:0]     sk_cnt_q;
	reg  [`PFS_TRK_W-1:0]     sk_left_q;
	wire                      lpt;
	wire                      f_valid;
	wire [7:0]                f_data;
	wire                      f_take;

	function [`PFS_CNT_W-1:0] cyc;
		input integer n;
		begin
			cyc = n[`PFS_CNT_W-1:0] - 1'b1;
		end
	endfunction

	assign lpt    = (port_mode_select == `PFS_MODE_PRINTER);
	assign f_take = (st_q == ST_IDLE) & lpt & !printer_busy & !want_read;

	pfs_fifo #(
		.WIDTH (`PFS_FIFO_W),
		.DEPTH (FIFO_DEPTH),
		.AW    ($clog2(FIFO_DEPTH))
	) i_pfs_fifo (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.in_data   (tx_byte),
		.out_valid (f_valid),
		.out_ready (f_take),
		.out_data  (f_data)
	);

	// Printer byte transfer
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q                       <= ST_IDLE;
			cnt_q                      <= `PFS_CNT_RST;
			byte_q                     <= `PFS_BYTE_RST;
			printer_latch_pulse_n_oe_q <= 1'b0;
		end else if (!lpt) begin
			st_q                       <= ST_IDLE;
			printer_latch_pulse_n_oe_q <= 1'b0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					printer_latch_pulse_n_oe_q <= 1'b0;
					if (f_take && f_valid) begin
						byte_q <= f_data;
						cnt_q  <= cyc(SETUP_CYC);
						st_q   <= ST_SETUP;
					end
				end
				ST_SETUP: begin
					if (cnt_q == `PFS_CNT_RST) begin
						printer_latch_pulse_n_oe_q <= 1'b1;
						cnt_q                      <= cyc(STROBE_CYC);
						st_q                       <= ST_PULSE;
					end else
						cnt_q <= cnt_q - 1'b1;
				end
				ST_PULSE: begin
					if (cnt_q == `PFS_CNT_RST) begin
						printer_latch_pulse_n_oe_q <= 1'b0;
						cnt_q                      <= cyc(HOLD_CYC);
						st_q                       <= ST_HOLD;
					end else
						cnt_q <= cnt_q - 1'b1;
				end
				ST_HOLD: begin
					if (cnt_q == `PFS_CNT_RST)
						st_q <= ST_IDLE;
					else
						cnt_q <= cnt_q - 1'b1;
				end
				default: begin
					st_q                       <= ST_IDLE;
					printer_latch_pulse_n_oe_q <= 1'b0;
				end
			endcase
		end
	end

	// Printer controls, data bus and status
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			auto_line_feed_n_oe_q     <= 1'b0;
			printer_init_n_oe_q       <= 1'b0;
			printer_select_out_n_oe_q <= 1'b0;
			printer_byte_bus_o_q      <= `PFS_BYTE_RST;
			printer_byte_bus_oe_q     <= 1'b0;
			rx_valid_q                <= 1'b0;
			rx_byte_q                 <= `PFS_BYTE_RST;
			stat_fault_q              <= 1'b0;
			stat_paper_out_q          <= 1'b0;
			stat_online_q             <= 1'b0;
			stat_busy_q               <= 1'b0;
			stat_ack_q                <= 1'b0;
		end else begin
			auto_line_feed_n_oe_q     <= lpt & want_auto_feed;
			printer_init_n_oe_q       <= lpt & want_init;
			printer_select_out_n_oe_q <= lpt & want_select;
			printer_byte_bus_o_q      <= byte_q;
			// Bus stays driven until a started transfer has ended
			printer_byte_bus_oe_q     <= lpt & (!want_read | (st_q != ST_IDLE));
			rx_valid_q                <= lpt & want_read & !printer_ack_n;
			rx_byte_q                 <= printer_byte_bus_i;
			stat_fault_q              <= lpt & !printer_fault_n;
			stat_paper_out_q          <= lpt & paper_out_in;
			stat_online_q             <= lpt & printer_online_in;
			stat_busy_q               <= lpt & printer_busy;
			stat_ack_q                <= lpt & !printer_ack_n;
		end
	end

	// Floppy seek: one step pulse per track
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sk_q             <= SK_IDLE;
			sk_cnt_q         <= `PFS_CNT_RST;
			sk_left_q        <= `PFS_TRK_RST;
			seek_busy_q      <= 1'b0;
			head_step_n_oe_q <= 1'b0;
			head_dir_oe_q    <= 1'b0;
		end else begin
			case (sk_q)
				SK_IDLE: begin
					head_step_n_oe_q <= 1'b0;
					seek_busy_q      <= 1'b0;
					if (!lpt && seek_start && seek_tracks != `PFS_TRK_RST) begin
						head_dir_oe_q    <= !seek_outward;
						sk_left_q        <= seek_tracks - 1'b1;
						sk_cnt_q         <= cyc(STEP_CYC);
						head_step_n_oe_q <= 1'b1;
						seek_busy_q      <= 1'b1;
						sk_q             <= SK_PULSE;
					end
				end
				SK_PULSE: begin
					if (lpt) begin
						head_step_n_oe_q <= 1'b0;
						sk_q             <= SK_IDLE;
					end else if (sk_cnt_q == `PFS_CNT_RST) begin
						head_step_n_oe_q <= 1'b0;
						sk_cnt_q         <= cyc(GAP_CYC);
						sk_q             <= SK_GAP;
					end else
						sk_cnt_q <= sk_cnt_q - 1'b1;
				end
				SK_GAP: begin
					if (lpt)
						sk_q <= SK_IDLE;
					else if (sk_cnt_q != `PFS_CNT_RST)
						sk_cnt_q <= sk_cnt_q - 1'b1;
					else if (sk_left_q == `PFS_TRK_RST)
						sk_q <= SK_IDLE;
					else begin
						sk_left_q        <= sk_left_q - 1'b1;
						sk_cnt_q         <= cyc(STEP_CYC);
						head_step_n_oe_q <= 1'b1;
						sk_q             <= SK_PULSE;
					end
				end
				default: begin
					sk_q             <= SK_IDLE;
					head_step_n_oe_q <= 1'b0;
				end
			endcase
			if (lpt)
				head_dir_oe_q <= 1'b0;
		end
	end

	// Floppy drive controls and status
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			density_choice_oe_q   <= 1'b0;
			drive_activate_n_oe_q <= 1'b0;
			spindle_on_n_oe_q     <= 1'b0;
			head_choice_oe_q      <= 1'b0;
			write_stream_n_oe_q   <= 1'b0;
			write_gate_out_n_oe_q <= 1'b0;
			fd_index_q            <= 1'b0;
			fd_track0_q           <= 1'b0;
			fd_protected_q        <= 1'b0;
			fd_read_bit_q         <= 1'b0;
			fd_changed_q          <= 1'b0;
		end else begin
			density_choice_oe_q   <= !lpt & !want_high_density;
			drive_activate_n_oe_q <= !lpt & want_drive;
			spindle_on_n_oe_q     <= !lpt & want_motor;
			head_choice_oe_q      <= !lpt & !want_head1;
			write_gate_out_n_oe_q <= !lpt & wr_active;
			write_stream_n_oe_q   <= !lpt & wr_active & wr_bit;
			fd_index_q            <= !lpt & !index_hole_n;
			fd_track0_q           <= !lpt & !outermost_track_in;
			fd_protected_q        <= !lpt & !write_protect_n;
			fd_read_bit_q         <= !lpt & !read_stream_n;
			fd_changed_q          <= !lpt & !disk_changed_in;
		end
	end
endmodule
`default_nettype wire

// [pkg/pfs_consts.vh]
`ifndef PFS_CONSTS_VH
`define PFS_CONSTS_VH

// Mode select level
`define PFS_MODE_PRINTER   1'b1
`define PFS_MODE_FLOPPY    1'b0

// Printer strobe timing (ns) and derived cycles at clock period
`define PFS_CLK_PERIOD_NS  10
`define PFS_SETUP_NS       500
`define PFS_STROBE_NS      1000
`define PFS_HOLD_NS        500
`define PFS_SETUP_CYC      ((`PFS_SETUP_NS + `PFS_CLK_PERIOD_NS - 1) / `PFS_CLK_PERIOD_NS)
`define PFS_STROBE_CYC     ((`PFS_STROBE_NS + `PFS_CLK_PERIOD_NS - 1) / `PFS_CLK_PERIOD_NS)
`define PFS_HOLD_CYC       ((`PFS_HOLD_NS + `PFS_CLK_PERIOD_NS - 1) / `PFS_CLK_PERIOD_NS)

// Floppy step timing (ns)
`define PFS_STEP_PULSE_NS  1000
`define PFS_STEP_GAP_NS    3000
`define PFS_STEP_PULSE_CYC ((`PFS_STEP_PULSE_NS + `PFS_CLK_PERIOD_NS - 1) / `PFS_CLK_PERIOD_NS)
`define PFS_STEP_GAP_CYC   ((`PFS_STEP_GAP_NS + `PFS_CLK_PERIOD_NS - 1) / `PFS_CLK_PERIOD_NS)

// Widths
`define PFS_CNT_W          12
`define PFS_TRK_W          8
`define PFS_FIFO_W         8
`define PFS_FIFO_D         16

// Reset values
`define PFS_BYTE_RST       8'h00
`define PFS_CNT_RST        12'h000
`define PFS_TRK_RST        8'h00

`endif

// [hdl/pfs_fifo.v]
`timescale 1ns/1ps
`default_nettype none
module pfs_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// Clock and reset
	input  wire             mclk,
	input  wire             rst_n,
	// Fill side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// Drain side
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0]    wr_q;
	reg [AW-1:0]    rd_q;
	reg [AW:0]      cnt_q;
	reg [AW:0]      cnt_d;
	reg             full_q;
	wire            push;
	wire            pop;

	// Ready comes from a registered full flag, not from count logic
	assign in_ready  = !full_q;
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always @* begin
		cnt_d = cnt_q;
		if (push && !pop)
			cnt_d = cnt_q + 1'b1;
		else if (pop && !push)
			cnt_d = cnt_q - 1'b1;
	end

	always @(posedge mclk) begin
		if (push)
			mem_q[wr_q] <= in_data;
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q  <= {AW{1'b0}};
			rd_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
			full_q <= 1'b0;
		end else begin
			if (push)
				wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
			if (pop)
				rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
			cnt_q  <= cnt_d;
			full_q <= (cnt_d == DEPTH[AW:0]);
		end
	end
endmodule
`default_nettype wire

// [verification/pfs_port_props.sv]
`timescale 1ns/1ps
`default_nettype none
module pfs_port_props #(
	parameter STROBE_CYC = 3,
	parameter STEP_CYC   = 2
) (
	// Clock, reset and host side
	input wire logic       mclk,
	input wire logic       rst_n,
	input wire logic       port_mode_select,
	input wire logic       want_auto_feed, want_init, want_select,
	input wire logic       want_high_density, want_drive, want_motor, want_head1,
	input wire logic       wr_active,
	input wire logic       seek_busy_q,
	// Pins
	input wire logic       printer_latch_pulse_n_oe_q, auto_line_feed_n_oe_q,
	input wire logic       printer_init_n_oe_q, printer_select_out_n_oe_q,
	input wire logic [7:0] printer_byte_bus_o_q,
	input wire logic       printer_byte_bus_oe_q,
	input wire logic       density_choice_oe_q, drive_activate_n_oe_q, spindle_on_n_oe_q,
	input wire logic       head_choice_oe_q, head_step_n_oe_q, write_gate_out_n_oe_q
);
	logic [11:0] stb_n_q;
	logic [11:0] stp_n_q;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Lengths of the pulse currently low on the pin
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stb_n_q <= 12'h000;
			stp_n_q <= 12'h000;
		end else begin
			stb_n_q <= printer_latch_pulse_n_oe_q ? stb_n_q + 12'h001 : 12'h000;
			stp_n_q <= head_step_n_oe_q ? stp_n_q + 12'h001 : 12'h000;
		end
	end
	a_printer_off: assert property (!port_mode_select |=> !(printer_latch_pulse_n_oe_q || auto_line_feed_n_oe_q
		|| printer_init_n_oe_q || printer_select_out_n_oe_q || printer_byte_bus_oe_q)) else $error("printer pin driven");
	a_floppy_off: assert property (port_mode_select |=> !(density_choice_oe_q || drive_activate_n_oe_q
		|| spindle_on_n_oe_q || head_choice_oe_q || head_step_n_oe_q || write_gate_out_n_oe_q)) else $error("floppy pin driven");
	a_printer_ctl: assert property (port_mode_select |=> {auto_line_feed_n_oe_q, printer_init_n_oe_q,
		printer_select_out_n_oe_q} == {$past(want_auto_feed), $past(want_init), $past(want_select)}) else $error("control pins");
	a_floppy_map: assert property (!port_mode_select |=> {density_choice_oe_q, drive_activate_n_oe_q,
		spindle_on_n_oe_q, head_choice_oe_q} == {~$past(want_high_density), $past(want_drive), $past(want_motor),
		~$past(want_head1)}) else $error("drive pins");
	a_write_gate_out_cause: assert property (write_gate_out_n_oe_q |-> $past(wr_active) && !$past(port_mode_select))
		else $error("write gate without write");
	a_step_busy: assert property (head_step_n_oe_q |-> seek_busy_q) else $error("step outside seek");
	a_step_len: assert property ($fell(head_step_n_oe_q) |-> stp_n_q == 12'(STEP_CYC)) else $error("step width");
	a_strobe_len: assert property ($fell(printer_latch_pulse_n_oe_q) |-> stb_n_q == 12'(STROBE_CYC))
		else $error("strobe width");
	a_bus_hold: assert property (printer_latch_pulse_n_oe_q |-> printer_byte_bus_oe_q && $stable(printer_byte_bus_o_q))
		else $error("data moved under strobe");
	c_strobe: cover property ($rose(printer_latch_pulse_n_oe_q));
	c_step: cover property ($rose(head_step_n_oe_q));
	c_write_gate_out: cover property ($rose(write_gate_out_n_oe_q));
endmodule
bind pfs_port pfs_port_props #(.STROBE_CYC(STROBE_CYC), .STEP_CYC(STEP_CYC)) i_pfs_port_props (.*);
`default_nettype wire

// [verification/pfs_peer.sv]
`timescale 1ns/1ps
`default_nettype none
module pfs_peer (
	// Device pins
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        printer_latch_pulse_n_oe_q, printer_byte_bus_oe_q, head_step_n_oe_q, head_dir_oe_q,
	input wire logic [7:0]  printer_byte_bus_o_q,
	input wire logic [7:0]  busy_len,
	input wire logic        send_back,
	// Printer and drive answers
	output logic [7:0]      printer_byte_bus_i,
	output logic            printer_ack_n, printer_busy,
	output logic            index_hole_n, outermost_track_in, read_stream_n
);
	logic [7:0] cap [0:31];
	int         cap_n;
	int         bad_n;
	int         track;
	int         bc;
	logic       stb_q;
	logic       stp_q;
	logic       sb_q;
	logic [7:0] tick;
	// Released bus shows the inverse of the last value unless the printer answers
	assign printer_byte_bus_i = printer_byte_bus_oe_q ? printer_byte_bus_o_q :
		(send_back ? 8'h5a : ~printer_byte_bus_o_q);
	assign outermost_track_in = (track != 0);
	assign index_hole_n = (tick[5:0] != 6'h00);
	assign read_stream_n = tick[0];
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cap_n <= 0;
			bad_n <= 0;
			track <= 0;
			bc <= 0;
			stb_q <= 1'b0;
			stp_q <= 1'b0;
			sb_q <= 1'b0;
			tick <= 8'h00;
			printer_ack_n <= 1'b1;
			printer_busy <= 1'b0;
		end else begin
		tick <= tick + 8'h01;
		sb_q <= send_back;
		stb_q <= printer_latch_pulse_n_oe_q;
		stp_q <= head_step_n_oe_q;
		printer_ack_n <= 1'b1;
		if (printer_latch_pulse_n_oe_q && !stb_q) begin
			if (printer_busy)
				bad_n <= bad_n + 1;
			cap[cap_n[4:0]] <= printer_byte_bus_i;
			cap_n <= cap_n + 1;
			bc <= busy_len;
			printer_busy <= 1'b1;
		end else if (bc > 0)
			bc <= bc - 1;
		else if (printer_busy) begin
			printer_busy <= 1'b0;
			printer_ack_n <= 1'b0;
		end
		if (head_step_n_oe_q && !stp_q)
			track <= head_dir_oe_q ? track + 1 : track - 1;
		if (send_back && !sb_q)
			printer_ack_n <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [verification/test_printer_floppy_shared_port.sv]
`timescale 1ns/1ps
`default_nettype none
module test_printer_floppy_shared_port;
	logic       mclk = 0, rst_n = 0, port_mode_select = 1, tx_valid = 0, want_read = 0, wr_bit = 0, send_back = 0;
	logic       want_auto_feed = 0, want_init = 0, want_select = 0, seek_start = 0, seek_outward = 0;
	logic       want_high_density = 0, want_drive = 0, want_motor = 0, want_head1 = 0, wr_active = 0;
	logic       printer_fault_n = 1, paper_out_in = 0, printer_online_in = 0, write_protect_n = 1, disk_changed_in = 1;
	logic [7:0] tx_byte = 8'h00, seek_tracks = 8'h00, busy_len = 8'h14;
	wire        tx_ready, rx_valid_q, stat_fault_q, stat_paper_out_q, stat_online_q, stat_busy_q, stat_ack_q;
	wire        printer_latch_pulse_n_oe_q, auto_line_feed_n_oe_q, printer_init_n_oe_q, printer_select_out_n_oe_q;
	wire        printer_byte_bus_oe_q, printer_ack_n, printer_busy, seek_busy_q, fd_index_q, fd_track0_q;
	wire        fd_protected_q, fd_read_bit_q, fd_changed_q, density_choice_oe_q, index_hole_n, outermost_track_in;
	wire        read_stream_n, drive_activate_n_oe_q, spindle_on_n_oe_q, head_choice_oe_q, head_dir_oe_q;
	wire        head_step_n_oe_q, write_stream_n_oe_q, write_gate_out_n_oe_q;
	wire [7:0]  rx_byte_q, printer_byte_bus_i, printer_byte_bus_o_q;
	int         err_count = 0;
	int         check_count = 0;
	pfs_port #(.SETUP_CYC(2), .STROBE_CYC(3), .HOLD_CYC(2), .STEP_CYC(2), .GAP_CYC(3)) i_pfs_port (.*);
	pfs_peer i_pfs_peer (.*);
	initial forever #5 mclk = ~mclk;
	task test_done;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task hang(input string what);
		err_count++;
		$display("MISMATCH %0t wait ran out: %s", $time, what);
		test_done;
	endtask
	task t_print;
		int k;
		int n;
		int acks;
		int busy_bad;
		logic was_busy;
		k = 0;
		acks = 0;
		busy_bad = 0;
		for (n = 0; n < 40; n++) begin
			@(negedge mclk);
			if (!tx_ready)
				break;
			tx_byte = 8'h40 + k[7:0];
			tx_valid = 1;
			k++;
		end
		tx_valid = 0;
		chk(k[7:0], 8'd17, "bytes taken before refusal");
		was_busy = printer_busy;
		for (n = 0; n < 3000 && acks < 17; n++) begin
			@(negedge mclk);
			if (stat_ack_q === 1'b1)
				acks++;
			if (stat_busy_q !== was_busy)
				busy_bad++;
			was_busy = printer_busy;
		end
		if (acks < 17)
			hang("printer drain");
		chk(i_pfs_peer.cap_n[7:0], 8'd17, "strobes per acknowledge");
		chk({7'h00, busy_bad != 0}, 8'h00, "busy status follows pin");
		for (n = 0; n < 17; n++) chk(i_pfs_peer.cap[n], 8'h40 + n[7:0], "printed byte");
		chk(i_pfs_peer.bad_n[7:0], 8'h00, "strobe while busy");
		$display("test print done");
	endtask
	task t_reverse;
		int n;
		int seen;
		logic [7:0] got;
		seen = 0;
		got = 8'h00;
		@(negedge mclk);
		want_read = 1;
		repeat (2) @(negedge mclk);
		chk(printer_byte_bus_oe_q, 1'b0, "bus turned around");
		send_back = 1;
		for (n = 0; n < 8; n++) begin
			@(negedge mclk);
			if (rx_valid_q === 1'b1) begin
				seen++;
				got = rx_byte_q;
			end
		end
		send_back = 0;
		want_read = 0;
		chk(seen[7:0], 8'h01, "reverse acknowledges");
		chk(got, 8'h5a, "reverse byte");
		$display("test reverse done");
	endtask
	task t_ctrl;
		logic [2:0] v;
		int n;
		for (n = 0; n < 2; n++) begin
			v = n ? 3'b010 : 3'b101;
			@(negedge mclk);
			{want_auto_feed, want_init, want_select} = v;
			{printer_fault_n, paper_out_in, printer_online_in} = v;
			repeat (2) @(negedge mclk);
			chk({auto_line_feed_n_oe_q, printer_init_n_oe_q, printer_select_out_n_oe_q}, v, "controls");
			chk({stat_fault_q, stat_paper_out_q, stat_online_q}, {~v[2], v[1:0]}, "status");
		end
		port_mode_select = 0;
		repeat (2) @(negedge mclk);
		chk({printer_init_n_oe_q, printer_byte_bus_oe_q, stat_online_q}, 8'h00, "printer side released");
		$display("test controls done");
	endtask
	task do_seek(input logic [7:0] t, input logic o);
		int n;
		@(negedge mclk);
		seek_tracks = t;
		seek_outward = o;
		seek_start = 1;
		@(negedge mclk);
		seek_start = 0;
		for (n = 0; n < 5000 && seek_busy_q; n++) @(negedge mclk);
		if (seek_busy_q)
			hang("seek");
	endtask
	task t_floppy;
		logic [3:0] v;
		int n;
		int k;
		for (n = 0; n < 2; n++) begin
			v = n ? 4'b1001 : 4'b0110;
			@(negedge mclk);
			{want_high_density, want_drive, want_motor, want_head1} = v;
			{write_protect_n, disk_changed_in} = v[1:0];
			wr_active = v[2];
			wr_bit = 1;
			repeat (2) @(negedge mclk);
			chk({density_choice_oe_q, drive_activate_n_oe_q, spindle_on_n_oe_q, head_choice_oe_q},
				{~v[3], v[2:1], ~v[0]}, "drive pins");
			chk({fd_protected_q, fd_changed_q}, {~v[1], ~v[0]}, "drive flags");
			chk(write_gate_out_n_oe_q, v[2], "write gate");
			chk(write_stream_n_oe_q, v[2], "write data gated");
		end
		@(negedge mclk);
		wr_active = 1;
		wr_bit = 0;
		repeat (2) @(negedge mclk);
		chk({write_gate_out_n_oe_q, write_stream_n_oe_q}, 8'h02, "write zero bit");
		k = 0;
		for (n = 0; n < 64; n++) begin
			@(negedge mclk);
			if (fd_index_q === 1'b1)
				k++;
		end
		chk(k[7:0], 8'h01, "index pulses per turn");
		do_seek(8'h03, 1'b0);
		chk(i_pfs_peer.track[7:0], 8'h03, "inward seek");
		chk(fd_track0_q, 1'b0, "off track zero");
		do_seek(8'h03, 1'b1);
		chk(i_pfs_peer.track[7:0], 8'h00, "outward seek");
		chk(fd_track0_q, 1'b1, "on track zero");
		chk(fd_read_bit_q, read_stream_n, "read stream");
		$display("test floppy done");
	endtask
	initial begin
		repeat (20) @(negedge mclk);
		chk({printer_latch_pulse_n_oe_q, printer_byte_bus_oe_q, drive_activate_n_oe_q, write_gate_out_n_oe_q},
			8'h00, "pins in reset");
		rst_n = 1;
		t_print;
		t_reverse;
		t_ctrl;
		t_floppy;
		test_done;
	end
endmodule
`default_nettype wire
